// >>> vmecs_pkg.sv
package vmecs_pkg;

  // ***********************************************************
  // apb register map
  // ***********************************************************
  localparam logic [7:0] VMECS_OFS_CTRL     = 8'h00; // modes and request
  localparam logic [7:0] VMECS_OFS_PINCTL   = 8'h04; // pin-based controls
  localparam logic [7:0] VMECS_OFS_PRICTL   = 8'h08; // primary controls
  localparam logic [7:0] VMECS_OFS_SECCTL   = 8'h0c; // secondary controls
  localparam logic [7:0] VMECS_OFS_PIN0     = 8'h10; // pin cap allowed-0
  localparam logic [7:0] VMECS_OFS_PIN1     = 8'h14; // pin cap allowed-1
  localparam logic [7:0] VMECS_OFS_PRI0     = 8'h18; // primary cap allowed-0
  localparam logic [7:0] VMECS_OFS_PRI1     = 8'h1c; // primary cap allowed-1
  localparam logic [7:0] VMECS_OFS_SEC0     = 8'h20; // secondary allowed-0
  localparam logic [7:0] VMECS_OFS_SEC1     = 8'h24; // secondary allowed-1
  localparam logic [7:0] VMECS_OFS_MISC     = 8'h28; // target count, checks
  localparam logic [7:0] VMECS_OFS_STATUS   = 8'h2c; // last outcome (ro)

  // ***********************************************************
  // ctrl register fields
  // ***********************************************************
  localparam int VMECS_CTRL_GO     = 0; // write 1: request entry (self clr)
  localparam int VMECS_CTRL_RESUME = 1; // 0 first entry, 1 resume entry
  localparam int VMECS_CTRL_V86    = 2; // virtual-8086 mode
  localparam int VMECS_CTRL_COMPAT = 3; // compatibility mode
  localparam int VMECS_CTRL_CURCTX = 4; // current context structure exists
  localparam int VMECS_CTRL_SSBLK  = 5; // stack-segment load shadow
  localparam int VMECS_CTRL_SMM    = 6; // in system management mode
  localparam int VMECS_CTRL_ESMM   = 7; // enter-management-mode control
  localparam int VMECS_CTRL_TF     = 8; // trap flag
  localparam int VMECS_CTRL_CLEAR  = 9; // write 1: context clear (self clr)
  localparam int VMECS_CTRL_CPL_LO = 10; // privilege level, 2 bits
  localparam int VMECS_MISC_HOSTF  = 8; // host-state check fails
  localparam int VMECS_MISC_GUESTF = 9; // guest-state check fails
  localparam int VMECS_MISC_MSRF   = 10; // msr load fails
  localparam int VMECS_SEC_ACT_BIT = 31; // activate-secondary in primary

  // ***********************************************************
  // reset values and limits
  // ***********************************************************
  localparam logic [31:0] VMECS_RST_CTRL = 32'h0000_0000;
  localparam logic [31:0] VMECS_RST_ZERO = 32'h0000_0000;
  localparam logic [7:0]  VMECS_MAX_CR3T = 8'h04;
  localparam logic [7:0]  VMECS_VEC_UD   = 8'h06; // invalid opcode
  localparam logic [7:0]  VMECS_VEC_GP   = 8'h0d; // general protection
  localparam logic [7:0]  VMECS_VEC_DB   = 8'h01; // single step debug

  // error numbers (values arbitrary within this block)
  localparam logic [7:0] VMECS_ERR_LAUNCH  = 8'h04;
  localparam logic [7:0] VMECS_ERR_RESUME  = 8'h05;
  localparam logic [7:0] VMECS_ERR_CTL     = 8'h07;
  localparam logic [7:0] VMECS_ERR_HOST    = 8'h08;
  localparam logic [7:0] VMECS_ERR_SSBLK   = 8'h1a;

  // outcome kinds
  typedef enum logic [2:0] {
    VMECS_OUT_NONE, VMECS_OUT_OK, VMECS_OUT_FAULT,
    VMECS_OUT_FLAG, VMECS_OUT_HOST
  } vmecs_out_e;

  // one entry outcome as presented to the pipeline
  typedef struct packed {
    vmecs_out_e kind;
    logic       zero_flag;
    logic       carry_flag;
    logic [7:0] fault_vec;
    logic [7:0] err_num;
    logic       single_step;
    logic       smm_return;
  } vmecs_res_s;

endpackage

// >>> vmecs_seq.sv
// Summary of operation
// - first entry needs clear; resume needs launched
// - basic checks precede control and host checks
// - guest stage follows control and host checks
// - register load after guest stage, may fail
// - first entry success marks structure launched
// - ordinary faults delivered, no failure flag
// - zero flag with structure, else carry flag
// - guest or load failure loads host state
// - trap flag single-steps only flag failures
// - entry in management mode may return
// - v86 or compatibility mode: invalid opcode
// - nonzero privilege level: general protection
// - no structure: carry set, next instruction
// - ordered: shadow, launch clear, launched
// - ordered failure sets zero flag, error
// - control and host checks any order
// - control or host failure: zero, error
// - pin controls reserved bits must match
// - primary controls reserved bits must match
// - secondary checked only when activated
// - target count above four fails entry
`timescale 1ns/100ps
`default_nettype none
module vmecs_seq
  import vmecs_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        entry_req,
  input  wire logic        entry_resume,
  output logic             entry_busy,
  output var vmecs_res_s   entry_res,
  output logic             entry_done,
  output logic             launched
);

  // all checks below share the core clock and its reset
  default clocking cb_core @(posedge pclk); endclocking
  default disable iff (!presetn);

  // ***********************************************************
  // registers
  // ***********************************************************
  logic [31:0] ctrl_r, pinctl_r, prictl_r, secctl_r;
  logic [31:0] pin0_r, pin1_r, pri0_r, pri1_r, sec0_r, sec1_r, misc_r;
  logic [31:0] status_r;
  logic        launched_r;
  vmecs_res_s  res_r;
  logic        done_r;
  logic        resume_r;

  typedef enum logic [2:0] {
    ST_IDLE, ST_BASIC, ST_CTLHOST, ST_GUEST, ST_MSR, ST_DONE
  } vmecs_st_e;
  vmecs_st_e st_r;

  logic wr_en, sw_go, go;
  assign wr_en = psel && penable && pwrite;
  assign sw_go = wr_en && paddr == VMECS_OFS_CTRL && pwdata[VMECS_CTRL_GO];
  assign go    = (entry_req || sw_go) && st_r == ST_IDLE;
  assign pready     = 1'b1;
  assign entry_busy = st_r != ST_IDLE;

  // ***********************************************************
  // apb slave
  // ***********************************************************
  logic mapped;
  always_comb begin
    mapped = 1'b1;
    prdata = 32'h0000_0000;
    case (paddr)
      VMECS_OFS_CTRL:   prdata = ctrl_r;
      VMECS_OFS_PINCTL: prdata = pinctl_r;
      VMECS_OFS_PRICTL: prdata = prictl_r;
      VMECS_OFS_SECCTL: prdata = secctl_r;
      VMECS_OFS_PIN0:   prdata = pin0_r;
      VMECS_OFS_PIN1:   prdata = pin1_r;
      VMECS_OFS_PRI0:   prdata = pri0_r;
      VMECS_OFS_PRI1:   prdata = pri1_r;
      VMECS_OFS_SEC0:   prdata = sec0_r;
      VMECS_OFS_SEC1:   prdata = sec1_r;
      VMECS_OFS_MISC:   prdata = misc_r;
      VMECS_OFS_STATUS: prdata = status_r;
      default:          mapped = 1'b0;
    endcase
  end
  // unmapped addresses answer with an error, never a hang
  assign pslverr = psel && penable && !mapped;

  // software-writable configuration; go and clear never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_r   <= VMECS_RST_CTRL;
      pinctl_r <= VMECS_RST_ZERO;
      prictl_r <= VMECS_RST_ZERO;
      secctl_r <= VMECS_RST_ZERO;
      pin0_r   <= VMECS_RST_ZERO;
      pin1_r   <= VMECS_RST_ZERO;
      pri0_r   <= VMECS_RST_ZERO;
      pri1_r   <= VMECS_RST_ZERO;
      sec0_r   <= VMECS_RST_ZERO;
      sec1_r   <= VMECS_RST_ZERO;
      misc_r   <= VMECS_RST_ZERO;
    end else if (wr_en) begin
      case (paddr)
        VMECS_OFS_CTRL: begin
          ctrl_r <= pwdata & ~(32'h1 << VMECS_CTRL_CLEAR) & ~32'h1;
        end
        VMECS_OFS_PINCTL: pinctl_r <= pwdata;
        VMECS_OFS_PRICTL: prictl_r <= pwdata;
        VMECS_OFS_SECCTL: secctl_r <= pwdata;
        VMECS_OFS_PIN0:   pin0_r   <= pwdata;
        VMECS_OFS_PIN1:   pin1_r   <= pwdata;
        VMECS_OFS_PRI0:   pri0_r   <= pwdata;
        VMECS_OFS_PRI1:   pri1_r   <= pwdata;
        VMECS_OFS_SEC0:   sec0_r   <= pwdata;
        VMECS_OFS_SEC1:   sec1_r   <= pwdata;
        VMECS_OFS_MISC:   misc_r   <= pwdata;
        default: ;
      endcase
    end
  end

  // ***********************************************************
  // check terms
  // ***********************************************************
  logic [1:0] current_privilege_level;
  logic       ctx, sec_act, ctl_bad, host_bad;
  logic       pin_bad, pri_bad, sec_bad, cr3_bad;
  logic       smm_ret;
  assign current_privilege_level = ctrl_r[VMECS_CTRL_CPL_LO+1:VMECS_CTRL_CPL_LO];
  assign ctx = ctrl_r[VMECS_CTRL_CURCTX];
  // pin reserved bits: allowed-0 must be set, allowed-1 bound
  assign pin_bad = |((pin0_r & ~pinctl_r) | (pinctl_r & ~pin1_r));
  assign pri_bad = |((pri0_r & ~prictl_r) | (prictl_r & ~pri1_r));
  // unsupported activation means secondary taken as zero
  assign sec_act = prictl_r[VMECS_SEC_ACT_BIT] & pri1_r[VMECS_SEC_ACT_BIT];
  assign sec_bad = sec_act &&
                   |((sec0_r & ~secctl_r) | (secctl_r & ~sec1_r));
  assign cr3_bad = misc_r[7:0] > VMECS_MAX_CR3T;
  // all control checks fold into one verdict, no fixed order
  assign ctl_bad  = pin_bad | pri_bad | sec_bad | cr3_bad;
  assign host_bad = misc_r[VMECS_MISC_HOSTF];
  assign smm_ret = ctrl_r[VMECS_CTRL_SMM] & ~ctrl_r[VMECS_CTRL_ESMM];

  // ***********************************************************
  // sequencer
  // ***********************************************************
  vmecs_res_s res_nxt;
  always_comb begin
    res_nxt = '0;
    res_nxt.kind = VMECS_OUT_NONE;
    res_nxt.smm_return = smm_ret;
    case (st_r)
      ST_BASIC: begin
        if (ctrl_r[VMECS_CTRL_V86] || ctrl_r[VMECS_CTRL_COMPAT]) begin
          res_nxt.kind = VMECS_OUT_FAULT;
          res_nxt.fault_vec = VMECS_VEC_UD;
        end else if (current_privilege_level != 2'b00) begin
          res_nxt.kind = VMECS_OUT_FAULT;
          res_nxt.fault_vec = VMECS_VEC_GP;
        end else if (!ctx) begin
          res_nxt.kind = VMECS_OUT_FLAG;
          res_nxt.carry_flag = 1'b1;
        // ordered structure checks, zero flag and error
        end else if (ctrl_r[VMECS_CTRL_SSBLK]) begin
          res_nxt.kind = VMECS_OUT_FLAG;
          res_nxt.zero_flag = 1'b1;
          res_nxt.err_num = VMECS_ERR_SSBLK;
        end else if (!resume_r && launched_r) begin
          res_nxt.kind = VMECS_OUT_FLAG;
          res_nxt.zero_flag = 1'b1;
          res_nxt.err_num = VMECS_ERR_LAUNCH;
        end else if (resume_r && !launched_r) begin
          res_nxt.kind = VMECS_OUT_FLAG;
          res_nxt.zero_flag = 1'b1;
          res_nxt.err_num = VMECS_ERR_RESUME;
        end
      end
      ST_CTLHOST: begin
        // control or host failure, zero flag with error
        if (ctl_bad || host_bad) begin
          res_nxt.kind = VMECS_OUT_FLAG;
          res_nxt.zero_flag = 1'b1;
          res_nxt.err_num = ctl_bad ? VMECS_ERR_CTL : VMECS_ERR_HOST;
        end
      end
      ST_GUEST: begin
        if (misc_r[VMECS_MISC_GUESTF]) begin
          res_nxt.kind = VMECS_OUT_HOST;
        end
      end
      ST_MSR: begin
        // register load may fail, host-state load
        if (misc_r[VMECS_MISC_MSRF]) begin
          res_nxt.kind = VMECS_OUT_HOST;
        end else begin
          res_nxt.kind = VMECS_OUT_OK;
        end
      end
      default: ;
    endcase
    // single step only on flag failures; faults carry no flag
    res_nxt.single_step = (res_nxt.kind == VMECS_OUT_FLAG) &&
                          ctrl_r[VMECS_CTRL_TF];
  end

  // state walk: each stage one cycle, stops at first verdict
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r     <= ST_IDLE;
      resume_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (go) begin
            st_r     <= ST_BASIC;
            // software go takes its resume choice from the same write
            resume_r <= entry_req ? entry_resume : pwdata[VMECS_CTRL_RESUME];
          end
        end
        ST_BASIC:   st_r <= (res_nxt.kind == VMECS_OUT_NONE) ? ST_CTLHOST
                                                           : ST_DONE;
        // guest stage only after control and host pass
        ST_CTLHOST: st_r <= (res_nxt.kind == VMECS_OUT_NONE) ? ST_GUEST
                                                           : ST_DONE;
        ST_GUEST:   st_r <= (res_nxt.kind == VMECS_OUT_NONE) ? ST_MSR
                                                           : ST_DONE;
        ST_MSR:     st_r <= ST_DONE;
        ST_DONE:    st_r <= ST_IDLE;
        default:    st_r <= ST_IDLE;
      endcase
    end
  end

  // outcome latched and pulsed for one cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      res_r  <= '0;
      done_r <= 1'b0;
    end else begin
      done_r <= 1'b0;
      if (st_r != ST_IDLE && st_r != ST_DONE &&
          res_nxt.kind != VMECS_OUT_NONE) begin
        res_r  <= res_nxt;
        done_r <= 1'b1;
      end
    end
  end
  assign entry_res  = res_r;
  assign entry_done = done_r;

  // launch state set on first-entry success, before injection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      launched_r <= 1'b0;
    end else if (st_r == ST_MSR && res_nxt.kind == VMECS_OUT_OK &&
                 !resume_r) begin
      launched_r <= 1'b1;
    end else if (wr_en && paddr == VMECS_OFS_CTRL &&
                 pwdata[VMECS_CTRL_CLEAR] && st_r == ST_IDLE) begin
      launched_r <= 1'b0;
    end
  end
  assign launched = launched_r;

  // status: kind, launch state, error, vector, flags
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_r <= VMECS_RST_ZERO;
    end else if (done_r) begin
      status_r <= {res_r.single_step, res_r.smm_return, res_r.zero_flag,
                   res_r.carry_flag, launched_r, res_r.kind,
                   res_r.fault_vec, res_r.err_num, 8'h00};
    end
  end

  // ***********************************************************
  // assertions
  // ***********************************************************
  sequence s_basic_pass;
    st_r == ST_BASIC && res_nxt.kind == VMECS_OUT_NONE;
  endsequence
  sequence s_ctl_pass;
    st_r == ST_CTLHOST && res_nxt.kind == VMECS_OUT_NONE;
  endsequence
  sequence s_basic_ok;
    st_r == ST_BASIC && !ctrl_r[VMECS_CTRL_V86] &&
    !ctrl_r[VMECS_CTRL_COMPAT] && current_privilege_level == 2'b00;
  endsequence

  AST_ORDER_BASIC: assert property (
    st_r == ST_CTLHOST |-> $past(st_r) == ST_BASIC)
    else $error("control stage without basic stage");
  AST_GUEST_AFTER: assert property (
    s_basic_pass ##1 s_ctl_pass |=> st_r == ST_GUEST)
    else $error("guest stage not reached after passes");
  AST_V86_UD: assert property (
    st_r == ST_BASIC && ctrl_r[VMECS_CTRL_V86] |=>
      entry_done && entry_res.fault_vec == VMECS_VEC_UD)
    else $error("v86 entry missed invalid opcode");
  AST_CPL_GP: assert property (
    st_r == ST_BASIC && !ctrl_r[VMECS_CTRL_V86] &&
    !ctrl_r[VMECS_CTRL_COMPAT] && current_privilege_level != 2'b00 |=>
      entry_done && entry_res.kind == VMECS_OUT_FAULT &&
      entry_res.fault_vec == VMECS_VEC_GP && !entry_res.zero_flag)
    else $error("nonzero privilege missed protection fault");
  AST_NOCTX_CF: assert property (
    entry_done && entry_res.carry_flag |->
      !entry_res.zero_flag && entry_res.kind == VMECS_OUT_FLAG)
    else $error("carry failure malformed");
  AST_NOCTX_GO: assert property (
    s_basic_ok ##0 !ctx |=> entry_done && entry_res.carry_flag)
    else $error("missing structure not flagged by carry");
  AST_SSBLK: assert property (
    s_basic_ok ##0 (ctx && ctrl_r[VMECS_CTRL_SSBLK]) |=>
      entry_done && entry_res.zero_flag &&
      entry_res.err_num == VMECS_ERR_SSBLK)
    else $error("shadow blocking not reported first");
  AST_RESUME_GATE: assert property (
    s_basic_ok ##0 (ctx && !ctrl_r[VMECS_CTRL_SSBLK] && resume_r &&
    !launched_r) |=> entry_done && entry_res.err_num == VMECS_ERR_RESUME)
    else $error("resume of unlaunched structure accepted");
  AST_CTL_FAIL: assert property (
    st_r == ST_CTLHOST && (ctl_bad || host_bad) |=>
      entry_done && entry_res.zero_flag && !entry_res.carry_flag)
    else $error("control or host failure not flagged");
  AST_GUEST_HOST: assert property (
    st_r == ST_GUEST && misc_r[VMECS_MISC_GUESTF] |=>
      entry_done && entry_res.kind == VMECS_OUT_HOST)
    else $error("guest failure did not load host state");
  AST_MSR_FAIL: assert property (
    st_r == ST_MSR && misc_r[VMECS_MISC_MSRF] |=>
      entry_done && entry_res.kind == VMECS_OUT_HOST &&
      !entry_res.single_step)
    else $error("register load failure not reported");
  AST_FAULT_NOFLAG: assert property (
    entry_done && entry_res.kind == VMECS_OUT_FAULT |->
      !entry_res.zero_flag && !entry_res.carry_flag)
    else $error("fault outcome carried a failure flag");
  AST_SMM_RET: assert property (
    st_r == ST_MSR && !misc_r[VMECS_MISC_MSRF] |=>
      entry_res.smm_return == $past(smm_ret))
    else $error("management mode return misreported");
  AST_STEP: assert property (
    entry_done && entry_res.kind != VMECS_OUT_FLAG |-> !entry_res.single_step)
    else $error("single step on non-flag outcome");
  AST_LAUNCH: assert property (
    st_r == ST_MSR && !resume_r && !misc_r[VMECS_MISC_MSRF] |=> launched_r)
    else $error("launch state not set");
  AST_CR3: assert property (
    st_r == ST_CTLHOST && cr3_bad |=>
      entry_done && entry_res.err_num == VMECS_ERR_CTL)
    else $error("target count over limit accepted");
  AST_ONE_PULSE: assert property (
    entry_done |=> !entry_done)
    else $error("outcome longer than one cycle");
  AST_BUSY_SPAN: assert property (
    entry_done |-> entry_busy ##1 !entry_busy)
    else $error("busy did not end one cycle after outcome");

endmodule
`default_nettype wire

// >>> vmecs_pipe_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***********************************************************
// pipeline side model: issues guest entries
// ***********************************************************
module vmecs_pipe_model
  import vmecs_pkg::*;
(
  input  wire logic       pclk,
  input  wire logic       entry_busy,
  input  wire logic       entry_done,
  input  wire vmecs_res_s entry_res,
  output logic            entry_req,
  output logic            entry_resume
);
  // idle levels from time zero
  initial begin
    entry_req    = 1'b0;
    entry_resume = 1'b0;
  end

  // one entry: wait idle, optional stall, hold request for one take edge
  task automatic issue(input logic res, input int gap,
                       output vmecs_res_s r, output int lat,
                       output logic one_pulse);
    int n;
    n = 0;
    do begin
      @(negedge pclk);
      n++;
    end while (entry_busy !== 1'b0 && n < 50);
    repeat (gap) @(posedge pclk);
    @(posedge pclk);
    entry_req    <= 1'b1;
    entry_resume <= res;
    @(posedge pclk);
    entry_req    <= 1'b0;
    entry_resume <= ~res; // stale qualifier must not be trusted
    lat = 0;
    do begin
      @(negedge pclk);
      lat++;
    end while (entry_done !== 1'b1 && lat < 50);
    r = entry_res;
    one_pulse = (entry_busy === 1'b1);
    @(negedge pclk);
    // pulse gone and busy dropped one cycle after the outcome
    one_pulse = one_pulse && (entry_done === 1'b0) && (entry_busy === 1'b0);
    // a sequencer that never went idle counts as a timeout
    if (n >= 50) lat = 50;
  endtask
endmodule
`default_nettype wire

// >>> test_vmecs_seq.sv
`timescale 1ns/100ps
`default_nettype none
module test_vmecs_seq
  import vmecs_pkg::*;
;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        entry_req;
  logic        entry_resume;
  logic        entry_busy;
  vmecs_res_s  entry_res;
  logic        entry_done;
  logic        launched;
  int          num_errors;
  int          compares;
  logic        exp_l;
  logic [31:0] q;
  logic        e;

  vmecs_seq i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .entry_req(entry_req), .entry_resume(entry_resume),
    .entry_busy(entry_busy), .entry_res(entry_res),
    .entry_done(entry_done), .launched(launched));

  vmecs_pipe_model i_pipe (.pclk(pclk), .entry_busy(entry_busy),
    .entry_done(entry_done), .entry_res(entry_res),
    .entry_req(entry_req), .entry_resume(entry_resume));

  // 250 MHz core clock
  always #2 pclk = ~pclk;

  // ***********************************************************
  // helpers
  // ***********************************************************
  task automatic tally_and_finish();
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] x,
                       input logic [31:0] g);
    compares++;
    if (g !== x) begin
      num_errors++;
      $display("ERROR %s expected %h seen %h", nm, x, g);
    end
  endtask

  // apb master: setup, access until pready sampled high
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    q = prdata;
    e = pslverr;
    if (pready !== 1'b1) begin
      num_errors++;
      tally_and_finish();
    end
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  function automatic logic ctl_bad(input logic [31:0] pin, pri, sec, misc);
    ctl_bad = ((pin & 32'h0000_0001) != 32'h1) || ((pin & ~32'hff) != 0)
           || ((pri & ~32'h8000_00ff) != 0) || (misc[7:0] > VMECS_MAX_CR3T)
           || (pri[VMECS_SEC_ACT_BIT] && ((sec & ~32'h0000_000f) != 0));
  endfunction

  // program the structure, run one entry, compare with the reference
  task automatic run_case(input logic [31:0] c, pin, pri, sec, misc,
                          input logic res, input int gap);
    vmecs_res_s r;
    logic [2:0] ek;
    int         lat;
    int         el;
    logic       p1;
    logic       ezf;
    logic       ecf;
    logic [7:0] ev;
    logic [7:0] ee;
    apb(1'b1, VMECS_OFS_CTRL, (c & ~32'h201) | {30'h0, res, 1'b0});
    apb(1'b1, VMECS_OFS_PINCTL, pin);
    apb(1'b1, VMECS_OFS_PRICTL, pri);
    apb(1'b1, VMECS_OFS_SECCTL, sec);
    apb(1'b1, VMECS_OFS_MISC, misc);
    i_pipe.issue(res, gap, r, lat, p1);
    if (lat >= 50) begin
      num_errors++;
      tally_and_finish();
    end
    {ek, el, ezf, ecf, ev, ee} = {VMECS_OUT_FLAG, 2, 1'b1, 1'b0, 16'h0};
    if (c[VMECS_CTRL_V86] | c[VMECS_CTRL_COMPAT]) begin
      {ek, ezf, ev} = {VMECS_OUT_FAULT, 1'b0, VMECS_VEC_UD};
    end else if (c[11:10] != 2'b00) begin
      {ek, ezf, ev} = {VMECS_OUT_FAULT, 1'b0, VMECS_VEC_GP};
    end else if (!c[VMECS_CTRL_CURCTX]) begin
      {ezf, ecf} = 2'b01;
    end else if (c[VMECS_CTRL_SSBLK]) begin
      ee = VMECS_ERR_SSBLK;
    end else if (!res && exp_l) begin
      ee = VMECS_ERR_LAUNCH;
    end else if (res && !exp_l) begin
      ee = VMECS_ERR_RESUME;
    end else begin
      el = 3;
      if (ctl_bad(pin, pri, sec, misc)) begin
        ee = VMECS_ERR_CTL;
      end else if (misc[VMECS_MISC_HOSTF]) begin
        ee = VMECS_ERR_HOST;
      end else begin
        {ek, ezf, el} = {VMECS_OUT_HOST, 1'b0, 4};
        if (!misc[VMECS_MISC_GUESTF]) begin
          el = 5;
          if (!misc[VMECS_MISC_MSRF]) begin
            ek = VMECS_OUT_OK;
          end
        end
      end
    end
    if (ek == VMECS_OUT_OK && !res) begin
      exp_l = 1'b1;
    end
    check("kind", {29'h0, ek}, {29'h0, r.kind});
    check("latency", el, lat);
    check("done pulse", 1, {31'h0, p1});
    check("launched", {31'h0, exp_l}, {31'h0, launched});
    check("single step", {31'h0, c[VMECS_CTRL_TF] && ek == VMECS_OUT_FLAG},
          {31'h0, r.single_step});
    if (ek != VMECS_OUT_HOST) begin
      check("flags", {30'h0, ezf, ecf},
            {30'h0, r.zero_flag, r.carry_flag});
    end
    if (ek == VMECS_OUT_FAULT) begin
      check("vector", {24'h0, ev}, {24'h0, r.fault_vec});
    end
    if (ek == VMECS_OUT_FLAG && ezf) begin
      check("error", {24'h0, ee}, {24'h0, r.err_num});
    end
    if (ek == VMECS_OUT_OK) begin
      check("smm return",
            {31'h0, c[VMECS_CTRL_SMM] && !c[VMECS_CTRL_ESMM]},
            {31'h0, r.smm_return});
    end
  endtask

  // ***********************************************************
  // main sequence
  // ***********************************************************
  initial begin
    {pclk, presetn, psel, penable, pwrite} = 5'b00000;
    {paddr, pwdata} = 40'h0;
    {num_errors, compares, exp_l} = '0;
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    // reset values, read-only status, unmapped slot
    apb(1'b1, VMECS_OFS_STATUS, 32'hffff_ffff);
    for (int a = 0; a < 48; a += 4) begin
      apb(1'b0, a[7:0], 32'h0);
      check("reset value", 32'h0, q);
    end
    apb(1'b0, 8'h30, 32'h0);
    check("pslverr", 32'h1, {31'h0, e});
    $display("test registers done");
    apb(1'b1, VMECS_OFS_PIN0, 32'h0000_0001);
    apb(1'b1, VMECS_OFS_PIN1, 32'h0000_00ff);
    apb(1'b1, VMECS_OFS_PRI1, 32'h8000_00ff);
    apb(1'b1, VMECS_OFS_SEC1, 32'h0000_000f);
    run_case(32'h404, 1, 0, 0, 0, 0, 0);
    run_case(32'h018, 1, 0, 0, 0, 0, 3);
    run_case(32'h500, 1, 0, 0, 0, 0, 0);
    run_case(32'h100, 1, 0, 0, 0, 0, 0);
    run_case(32'h130, 0, 0, 0, 0, 1, 2);
    run_case(32'h110, 0, 0, 0, 0, 0, 0);
    run_case(32'h010, 1, 32'h100, 0, 0, 0, 0);
    run_case(32'h110, 1, 0, 32'hf0, 32'h200, 0, 0);
    run_case(32'h010, 1, 32'h8000_0000, 32'hf0, 0, 0, 0);
    run_case(32'h010, 1, 0, 0, 32'h005, 0, 0);
    run_case(32'h010, 1, 0, 0, 32'h104, 0, 1);
    run_case(32'h110, 1, 0, 0, 32'h400, 0, 0);
    run_case(32'h150, 1, 0, 0, 32'h004, 0, 0);
    run_case(32'h010, 1, 0, 0, 0, 0, 0);
    apb(1'b0, VMECS_OFS_STATUS, 32'h0);
    check("status", 32'h2b00_0400, q);
    run_case(32'h0d0, 1, 0, 0, 0, 1, 0);
    apb(1'b1, VMECS_OFS_CTRL, 32'h200);
    exp_l = 1'b0;
    run_case(32'h010, 1, 0, 0, 0, 1, 0);
    $display("test entries done");
    // reset while idle, after a launched entry, clears the launch state
    run_case(32'h010, 1, 0, 0, 0, 0, 0);
    // software go with the resume choice in the same write
    apb(1'b1, VMECS_OFS_CTRL, 32'h0000_0013);
    repeat (6) @(posedge pclk);
    apb(1'b0, VMECS_OFS_STATUS, 32'h0);
    check("software go", 32'h0900_0000, q);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(negedge pclk);
    check("launched after reset", 32'h0, {31'h0, launched});
    $display("test reset done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
